// [include/pdo_node_defs.svh]
// Register map, field positions, reset values and fixed numbers
// Included by the node design
`ifndef PDO_NODE_DEFS_SVH
`define PDO_NODE_DEFS_SVH

`define OFS_CFG        8'h00
`define OFS_TXTYPE     8'h04
`define OFS_GUARD      8'h08
`define OFS_HBPROD     8'h0C
`define OFS_HBCONS     8'h10
`define OFS_MAP        8'h14
`define OFS_STATUS     8'h18
`define OFS_IDS_TX     8'h1C
`define OFS_IDS_RX     8'h20

`define CFG_ID_MSB     6
`define CFG_MODE_BIT   8
`define GRD_TIME_MSB   15
`define GRD_FAC_LSB    16
`define GRD_FAC_MSB    23
`define HBC_NODE_LSB   16
`define HBC_NODE_MSB   22
`define HBC_ACT_BIT    31
`define MAP_TX_MSB     2
`define MAP_RX_LSB     4
`define MAP_RX_MSB     6
`define ST_GLOST_BIT   0
`define ST_HLOST_BIT   1
`define ST_WIN_BIT     8
`define ID_HI_LSB      16

`define COB_TPDO1      11'h180
`define COB_RPDO1      11'h200
`define COB_TPDO2      11'h280
`define COB_RPDO2      11'h300

`define TYPE_ACYC      8'h00
`define TYPE_CYC_MAX   8'hF0
`define TYPE_ASYNC     8'hFF
`define MAP_MAX        3'h4
`define MAP_RESET      3'h2
`define PDO1_LEN       4'h2

`define MS_NS          1000000
`define CLK_NS         20

`endif

// [include/pdo_node_pkg.sv]
// Types shared by the process-data and error-control node
// Numbers live in pdo_node_defs.svh
package pdo_node_pkg;

    typedef enum logic {
        EC_GUARDING = 1'b0,
        EC_HEARTBEAT = 1'b1
    } ec_mode_t;

    typedef enum logic {
        WIN_SHUT = 1'b0,
        WIN_OPEN = 1'b1
    } win_t;

endpackage : pdo_node_pkg

// [hw/pdo_node.sv]
// Process-data transmit and error control of a CANopen slave node
// Sits beside a CAN controller on pclk; event inputs are on pclk too
//
// How it works
// - Second pair uses 0x280/0x300 plus node
// - Type 0 acyclic, 1-240 cyclic, 255 async
// - Second pair mapping up to 4 objects
// - First pair mapping is fixed inside node
// - First pair identifiers are base plus node address
// - Guarding or heartbeat, one selected by config
// - Life time is guard time times factor
// - Node consumes heartbeat of one listed node
// - First pair uses 0x180/0x200 plus node
// - Acyclic sends changed data inside sync window
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ns
`include "pdo_node_defs.svh"

module pdo_node #(
    parameter int MS_CYCLES  = (`MS_NS + `CLK_NS - 1) / `CLK_NS,
    parameter int WIN_CYCLES = 1000,
    parameter int DATA_W     = 64
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  sync_pulse,
    input  wire logic                  guard_req,
    input  wire logic                  hb_rx,
    input  wire logic [6:0]            hb_rx_node,
    input  wire logic                  pdo1_valid,
    input  wire logic [15:0]           pdo1_data,
    input  wire logic                  pdo2_valid,
    input  wire logic [DATA_W-1:0]     pdo2_data,
    output logic                       tx_valid,
    input  wire logic                  tx_ready,
    output logic      [10:0]           tx_cob_id,
    output logic      [3:0]            tx_len,
    output logic      [DATA_W-1:0]     tx_data,
    output logic                       hb_tx,
    output logic                       guard_reply,
    output logic                       guard_lost,
    output logic                       hb_lost
);
    import pdo_node_pkg::*;

    typedef struct packed {
        logic [10:0]       cob;
        logic [3:0]        len;
        logic [DATA_W-1:0] data;
    } entry_t;

    typedef struct packed {
        logic [6:0]        node_id;
        ec_mode_t          mode;
        logic [7:0]        tx_type;
        logic [15:0]       guard_ms;
        logic [7:0]        life_fac;
        logic [15:0]       prod_ms;
        logic [15:0]       cons_ms;
        logic [6:0]        cons_node;
        logic              cons_act;
        logic [2:0]        map_tx;
        logic [2:0]        map_rx;
        logic              glost;
        logic              hlost;
        logic [31:0]       rdata;
        logic [31:0]       ms_div;
        logic [23:0]       guard_cnt;
        logic [15:0]       prod_cnt;
        logic [15:0]       cons_cnt;
        logic              hb_pulse;
        logic              grd_pulse;
        logic [15:0]       cur1;
        logic [15:0]       last1;
        logic [DATA_W-1:0] cur2;
        logic [DATA_W-1:0] last2;
        logic [7:0]        sync_cnt;
        logic              sync_due;
        win_t              win;
        logic [31:0]       win_cnt;
        logic [1:0][$bits(entry_t)-1:0] buf_mem;
        logic              wr_ptr;
        logic              rd_ptr;
        logic [1:0]        count;
    } st_t;

    st_t st;
    st_t next_st;

    // Identifier of a process-data object from its base and address
    function automatic logic [10:0] cob_of(input logic [10:0] base,
                                           input logic [6:0]  id);
        cob_of = base + {4'h0, id};
    endfunction : cob_of

    logic        wr_en;
    logic        rd_setup;
    logic        mapped;
    logic        ms_tick;
    logic        changed1;
    logic        changed2;
    logic        send2;
    logic        push;
    logic        pop;
    logic [23:0] life_ms;
    entry_t      new_entry;
    entry_t      head;

    always_comb begin
        case (paddr)
            `OFS_CFG, `OFS_TXTYPE, `OFS_GUARD, `OFS_HBPROD, `OFS_HBCONS,
            `OFS_MAP, `OFS_STATUS, `OFS_IDS_TX, `OFS_IDS_RX: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign wr_en    = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;

    assign ms_tick  = (st.ms_div == 32'(MS_CYCLES - 1));
    assign life_ms  = st.guard_ms * st.life_fac;
    assign changed1 = (st.cur1 != st.last1);
    assign changed2 = (st.cur2 != st.last2);

    always_comb begin
        send2 = 1'b0;
        if (st.tx_type == `TYPE_ASYNC) begin
            send2 = changed2;
        end else if (st.tx_type == `TYPE_ACYC) begin
            send2 = changed2 && (st.win == WIN_OPEN);
        end else if (st.tx_type <= `TYPE_CYC_MAX) begin
            send2 = st.sync_due;
        end
    end

    // First pair is always asynchronous with a fixed one-word mapping
    always_comb begin
        if (changed1) begin
            new_entry.cob  = cob_of(`COB_TPDO1, st.node_id);
            new_entry.len  = `PDO1_LEN;
            new_entry.data = DATA_W'(st.cur1);
        end else begin
            new_entry.cob  = cob_of(`COB_TPDO2, st.node_id);
            new_entry.len  = {st.map_tx, 1'b0};
            new_entry.data = st.cur2;
        end
    end

    // A full buffer holds the pending send back; a newer value written meanwhile replaces it
    assign push     = (changed1 || send2) && (st.count != 2'h2);
    assign head     = entry_t'(st.buf_mem[st.rd_ptr]);
    assign pop      = tx_valid && tx_ready;
    assign tx_valid = (st.count != 2'h0);

    always_comb begin
        next_st           = st;
        next_st.hb_pulse  = 1'b0;
        next_st.grd_pulse = 1'b0;
        next_st.ms_div    = ms_tick ? 32'h0 : st.ms_div + 32'h1;

        if (pdo1_valid) begin
            next_st.cur1 = pdo1_data;
        end
        if (pdo2_valid) begin
            next_st.cur2 = pdo2_data;
        end

        // Sync window and cycle counting
        if (st.win == WIN_OPEN) begin
            if (st.win_cnt == 32'h0) begin
                next_st.win = WIN_SHUT;
            end else begin
                next_st.win_cnt = st.win_cnt - 32'h1;
            end
        end
        if (sync_pulse) begin
            next_st.win     = WIN_OPEN;
            next_st.win_cnt = 32'(WIN_CYCLES - 1);
            if (st.sync_cnt + 8'h1 >= st.tx_type) begin
                next_st.sync_cnt = 8'h0;
                next_st.sync_due = 1'b1;
            end else begin
                next_st.sync_cnt = st.sync_cnt + 8'h1;
            end
        end

        if (push) begin
            next_st.buf_mem[st.wr_ptr] = new_entry;
            next_st.wr_ptr             = !st.wr_ptr;
            if (changed1) begin
                next_st.last1 = st.cur1;
            end else begin
                next_st.last2 = st.cur2;
                // Keep a due flag raised by this same sync
                if (!sync_pulse || st.sync_cnt + 8'h1 < st.tx_type) begin
                    next_st.sync_due = 1'b0;
                end
            end
        end
        if (pop) begin
            next_st.rd_ptr = !st.rd_ptr;
        end
        next_st.count = st.count + {1'b0, push} - {1'b0, pop};

        // Node guarding, or heartbeat production in heartbeat mode
        if (st.mode == EC_GUARDING) begin
            if (guard_req) begin
                next_st.guard_cnt = 24'h0;
                next_st.grd_pulse = 1'b1;
            end else if (ms_tick && st.guard_cnt != 24'hFFFFFF) begin
                next_st.guard_cnt = st.guard_cnt + 24'h1;
            end
            if (life_ms != 24'h0 && st.guard_cnt >= life_ms) begin
                next_st.glost = 1'b1;
            end
        end else begin
            next_st.guard_cnt = 24'h0;
            if (ms_tick && st.prod_ms != 16'h0) begin
                if (st.prod_cnt + 16'h1 >= st.prod_ms) begin
                    next_st.prod_cnt = 16'h0;
                    next_st.hb_pulse = 1'b1;
                end else begin
                    next_st.prod_cnt = st.prod_cnt + 16'h1;
                end
            end
        end

        // Heartbeat consumer for the listed node
        if (!st.cons_act || (hb_rx && hb_rx_node == st.cons_node)) begin
            next_st.cons_cnt = 16'h0;
        end else if (ms_tick && st.cons_cnt != 16'hFFFF) begin
            next_st.cons_cnt = st.cons_cnt + 16'h1;
        end

        // Register writes; hardware set wins over the clear
        if (wr_en) begin
            case (paddr)
                `OFS_CFG: begin
                    next_st.node_id = pwdata[`CFG_ID_MSB:0];
                    next_st.mode    = ec_mode_t'(pwdata[`CFG_MODE_BIT]);
                end
                `OFS_TXTYPE: begin
                    next_st.tx_type  = pwdata[7:0];
                    next_st.sync_cnt = 8'h0;
                    next_st.sync_due = 1'b0;
                end
                `OFS_GUARD: begin
                    next_st.guard_ms = pwdata[`GRD_TIME_MSB:0];
                    next_st.life_fac = pwdata[`GRD_FAC_MSB:`GRD_FAC_LSB];
                end
                `OFS_HBPROD: next_st.prod_ms = pwdata[15:0];
                `OFS_HBCONS: begin
                    next_st.cons_ms   = pwdata[15:0];
                    next_st.cons_node = pwdata[`HBC_NODE_MSB:`HBC_NODE_LSB];
                    next_st.cons_act  = pwdata[`HBC_ACT_BIT];
                end
                `OFS_MAP: begin
                    if (pwdata[`MAP_TX_MSB:0] <= `MAP_MAX) begin
                        next_st.map_tx = pwdata[`MAP_TX_MSB:0];
                    end
                    if (pwdata[`MAP_RX_MSB:`MAP_RX_LSB] <= `MAP_MAX) begin
                        next_st.map_rx = pwdata[`MAP_RX_MSB:`MAP_RX_LSB];
                    end
                end
                `OFS_STATUS: begin
                    if (pwdata[`ST_GLOST_BIT]) begin
                        next_st.glost = 1'b0;
                    end
                    if (pwdata[`ST_HLOST_BIT]) begin
                        next_st.hlost = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (st.mode == EC_GUARDING && life_ms != 24'h0 &&
            st.guard_cnt >= life_ms) begin
            next_st.glost = 1'b1;
        end
        if (st.cons_act && st.cons_ms != 16'h0 &&
            st.cons_cnt >= st.cons_ms) begin
            next_st.hlost = 1'b1;
        end

        // Read data captured in the setup phase
        if (rd_setup) begin
            next_st.rdata = 32'h0;
            case (paddr)
                `OFS_CFG: begin
                    next_st.rdata[`CFG_ID_MSB:0]  = st.node_id;
                    next_st.rdata[`CFG_MODE_BIT]  = st.mode;
                end
                `OFS_TXTYPE: next_st.rdata[7:0] = st.tx_type;
                `OFS_GUARD: begin
                    next_st.rdata[`GRD_TIME_MSB:0] = st.guard_ms;
                    next_st.rdata[`GRD_FAC_MSB:`GRD_FAC_LSB] = st.life_fac;
                end
                `OFS_HBPROD: next_st.rdata[15:0] = st.prod_ms;
                `OFS_HBCONS: begin
                    next_st.rdata[15:0] = st.cons_ms;
                    next_st.rdata[`HBC_NODE_MSB:`HBC_NODE_LSB] = st.cons_node;
                    next_st.rdata[`HBC_ACT_BIT] = st.cons_act;
                end
                `OFS_MAP: begin
                    next_st.rdata[`MAP_TX_MSB:0] = st.map_tx;
                    next_st.rdata[`MAP_RX_MSB:`MAP_RX_LSB] = st.map_rx;
                end
                `OFS_STATUS: begin
                    next_st.rdata[`ST_GLOST_BIT] = st.glost;
                    next_st.rdata[`ST_HLOST_BIT] = st.hlost;
                    next_st.rdata[`ST_WIN_BIT]   = st.win;
                end
                `OFS_IDS_TX: begin
                    next_st.rdata[10:0] = cob_of(`COB_TPDO1, st.node_id);
                    next_st.rdata[`ID_HI_LSB +: 11] =
                        cob_of(`COB_TPDO2, st.node_id);
                end
                `OFS_IDS_RX: begin
                    next_st.rdata[10:0] = cob_of(`COB_RPDO1, st.node_id);
                    next_st.rdata[`ID_HI_LSB +: 11] =
                        cob_of(`COB_RPDO2, st.node_id);
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st          <= '0;
            st.mode     <= EC_GUARDING;
            st.tx_type  <= `TYPE_ASYNC;
            st.map_tx   <= `MAP_RESET;
            st.map_rx   <= `MAP_RESET;
            st.win      <= WIN_SHUT;
        end else begin
            st <= next_st;
        end
    end

    assign prdata      = st.rdata;
    assign tx_cob_id   = head.cob;
    assign tx_len      = head.len;
    assign tx_data     = head.data;
    assign hb_tx       = st.hb_pulse;
    assign guard_reply = st.grd_pulse;
    assign guard_lost  = st.glost;
    assign hb_lost     = st.hlost;

endmodule : pdo_node

// [bench/pdo_node_monitor.sv]
// Port assertions for the process-data node
// Bound into every pdo_node; one pclk domain
`timescale 1ns/1ns
module pdo_node_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        guard_req,
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    input wire logic [10:0] tx_cob_id,
    input wire logic [3:0]  tx_len,
    input wire logic        hb_tx,
    input wire logic        guard_reply,
    input wire logic        guard_lost,
    input wire logic        hb_lost
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_stall;
        tx_valid && !tx_ready;
    endsequence
    sequence s_held;
        tx_valid && $stable(tx_cob_id) && $stable(tx_len);
    endsequence
    a_ready_high: assert property (pready) else $error("pready low");
    a_err_unmapped: assert property (psel && penable && paddr[1:0] == 2'h0
        |-> pslverr == (paddr > 8'h20)) else $error("wrong pslverr");
    a_head_held: assert property (s_stall |=> s_held)
        else $error("head changed while stalled");
    a_cob_known: assert property (tx_valid |->
        tx_cob_id[10:7] inside {4'h3, 4'h5}) else $error("bad cob id");
    a_first_len: assert property (tx_valid && tx_cob_id[10:7] == 4'h3
        |-> tx_len == 4'h2) else $error("first pair length");
    a_second_len: assert property (tx_valid && tx_cob_id[10:7] == 4'h5
        |-> tx_len <= 4'h8 && !tx_len[0]) else $error("second pair length");
    a_guard_answer: assert property (guard_reply |-> $past(guard_req))
        else $error("reply without request");
    a_hb_single: assert property (hb_tx |=> !hb_tx)
        else $error("heartbeat pulse too long");
    a_guard_sticky: assert property (guard_lost && !(psel && penable
        && pwrite && paddr == 8'h18 && pwdata[0]) |=> guard_lost)
        else $error("guard loss dropped");
    a_hb_sticky: assert property (hb_lost && !(psel && penable
        && pwrite && paddr == 8'h18 && pwdata[1]) |=> hb_lost)
        else $error("heartbeat loss dropped");
endmodule : pdo_node_monitor

bind pdo_node pdo_node_monitor mon_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .guard_req(guard_req), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_cob_id(tx_cob_id), .tx_len(tx_len), .hb_tx(hb_tx),
    .guard_reply(guard_reply), .guard_lost(guard_lost), .hb_lost(hb_lost));

// [bench/can_master_model.sv]
// Behavioural CAN master taking frames off the transmit stream
// Ready is the inverse of the stall input, registered one cycle late; frames are logged
`timescale 1ns/1ns
module can_master_model (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        stall,
    input wire logic        tx_valid,
    input wire logic [10:0] tx_cob_id,
    input wire logic [3:0]  tx_len,
    input wire logic [63:0] tx_data,
    output logic            tx_ready,
    output logic [10:0]     got_cob [16],
    output logic [3:0]      got_len [16],
    output logic [63:0]     got_data [16],
    output int              got_n
);
    // Takes frames only; never retypes or remaps the first pair
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ready <= 1'b0;
            got_n    <= 0;
        end else begin
            tx_ready <= !stall;
            if (tx_valid && tx_ready) begin
                got_cob[got_n[3:0]]  <= tx_cob_id;
                got_len[got_n[3:0]]  <= tx_len;
                got_data[got_n[3:0]] <= tx_data;
                got_n                <= got_n + 1;
            end
        end
    end
endmodule : can_master_model

// [bench/tb_top.sv]
// Self-checking bench for the process-data node
// APB and event pulses from here; a CAN master model takes frames
`timescale 1ns/1ns
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        sync_pulse, guard_req, hb_rx, pdo1_valid, pdo2_valid;
    logic        tx_valid, tx_ready, hb_tx, guard_reply, guard_lost;
    logic        hb_lost, stall, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0]  hb_rx_node;
    logic [15:0] pdo1_data;
    logic [63:0] pdo2_data, tx_data;
    logic [10:0] tx_cob_id, got_cob [16];
    logic [3:0]  tx_len, got_len [16];
    logic [63:0] got_data [16];
    int          got_n, fails, checks, nf, n;

    pdo_node #(.MS_CYCLES(10), .WIN_CYCLES(8)) pdo_node_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sync_pulse(sync_pulse), .guard_req(guard_req),
        .hb_rx(hb_rx), .hb_rx_node(hb_rx_node), .pdo1_valid(pdo1_valid),
        .pdo1_data(pdo1_data), .pdo2_valid(pdo2_valid),
        .pdo2_data(pdo2_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_cob_id(tx_cob_id), .tx_len(tx_len), .tx_data(tx_data),
        .hb_tx(hb_tx), .guard_reply(guard_reply), .guard_lost(guard_lost),
        .hb_lost(hb_lost));
    can_master_model can_master_model_i (.pclk(pclk), .presetn(presetn),
        .stall(stall), .tx_valid(tx_valid), .tx_cob_id(tx_cob_id),
        .tx_len(tx_len), .tx_data(tx_data), .tx_ready(tx_ready),
        .got_cob(got_cob), .got_len(got_len), .got_data(got_data),
        .got_n(got_n));

    always #10 pclk = ~pclk;

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // Kinds: 0 status word, 1 second pair, 2 sync, 3 guard, 4 heartbeat
    task automatic ev(input int k, input logic [63:0] d);
        case (k)
            0: begin pdo1_valid <= 1'b1; pdo1_data <= d[15:0]; end
            1: begin pdo2_valid <= 1'b1; pdo2_data <= d; end
            2: sync_pulse <= 1'b1;
            3: guard_req <= 1'b1;
            default: begin hb_rx <= 1'b1; hb_rx_node <= d[6:0]; end
        endcase
        @(posedge pclk);
        {pdo1_valid, pdo2_valid, sync_pulse, guard_req, hb_rx} <= 5'h00;
        @(posedge pclk);
    endtask : ev

    task automatic frame(input logic [10:0] c, input logic [3:0] l,
                         input logic [63:0] d);
        n = 0;
        while (got_n <= nf && n < 200) begin
            @(posedge pclk);
            n++;
        end
        if (got_n <= nf) begin
            fails++;
            $display("Error at %0t: frame %0d never came", $time, nf);
        end
        chk(got_cob[nf], c);
        chk(got_len[nf], l);
        chk(got_data[nf], d);
        nf++;
    endtask : frame

    task automatic quiet(input int c);
        repeat (c) @(posedge pclk);
        chk(got_n, nf);
    endtask : quiet

    task automatic tally_and_finish;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (6000) @(posedge pclk);
        fails++;
        $display("Error at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        {pclk, presetn, psel, penable, pwrite, stall} = 6'h00;
        {sync_pulse, guard_req, hb_rx, pdo1_valid, pdo2_valid} = 5'h00;
        {paddr, pwdata, hb_rx_node, pdo1_data, pdo2_data} = '0;
        {fails, checks, nf} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, 8'h04, 0); chk(rd, 32'hFF);
        apb(0, 8'h14, 0); chk(rd, 32'h22);
        apb(0, 8'h24, 0); chk({err, rd}, 33'h1_0000_0000);
        apb(1, 8'h00, 32'h05);
        apb(0, 8'h1C, 0); chk(rd, 32'h0285_0185);
        apb(0, 8'h20, 0); chk(rd, 32'h0305_0205);
        apb(1, 8'h14, 32'h25); apb(0, 8'h14, 0); chk(rd, 32'h22);
        apb(1, 8'h14, 32'h44); apb(0, 8'h14, 0); chk(rd, 32'h44);
        ev(0, 64'h1234); frame(11'h185, 4'h2, 64'h1234);
        ev(0, 64'h1234); quiet(20);
        ev(1, 64'hA1); frame(11'h285, 4'h8, 64'hA1);
        apb(1, 8'h04, 0);
        ev(1, 64'hB2); quiet(20);
        ev(2, 0); frame(11'h285, 4'h8, 64'hB2);
        apb(1, 8'h04, 32'h03);
        ev(2, 0); ev(2, 0); quiet(10);
        ev(2, 0); frame(11'h285, 4'h8, 64'hB2);
        apb(1, 8'h04, 32'hFF);
        stall <= 1'b1;
        ev(0, 64'h5678); ev(1, 64'hD4); ev(0, 64'h9ABC);
        repeat (4) @(posedge pclk);
        chk(tx_valid, 1); chk(got_n, nf);
        stall <= 1'b0;
        frame(11'h185, 4'h2, 64'h5678);
        frame(11'h285, 4'h8, 64'hD4);
        frame(11'h185, 4'h2, 64'h9ABC);
        ev(3, 0); chk(guard_reply, 1);
        apb(1, 8'h08, 32'h0003_0002);
        repeat (40) @(posedge pclk); chk(guard_lost, 0);
        repeat (35) @(posedge pclk); chk(guard_lost, 1);
        ev(3, 0); apb(1, 8'h18, 32'h01); chk(guard_lost, 0);
        apb(1, 8'h00, 32'h105);
        apb(1, 8'h0C, 32'h02);
        n = 0;
        while (hb_tx !== 1'b1 && n < 60) begin
            @(posedge pclk);
            n++;
        end
        chk(hb_tx, 1);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (hb_tx !== 1'b1 && n < 60);
        chk(n, 20);
        apb(1, 8'h10, 32'h8009_0003);
        repeat (4) begin
            ev(4, 64'h09);
            repeat (8) @(posedge pclk);
        end
        chk(hb_lost, 0);
        repeat (50) @(posedge pclk); chk(hb_lost, 1);
        tally_and_finish();
    end
endmodule : tb_top
